// ---- pcb_pkg.sv ----
`default_nettype none
package pcb_pkg;

    localparam int NUM_REGS = 26;
    localparam logic [4:0] REG_PROT1 = 5'h00;
    localparam logic [4:0] REG_PROT2 = 5'h01;
    localparam logic [4:0] REG_PROT3 = 5'h02;
    localparam logic [4:0] REG_TRACKING = 5'h03;
    localparam logic [4:0] REG_PHASE_CLOCK = 5'h04;
    localparam logic [4:0] REG_ON_DELAY = 5'h05;
    localparam logic [4:0] REG_OFF_DELAY = 5'h06;
    localparam logic [4:0] REG_SETPOINT = 5'h07;
    localparam logic [4:0] REG_CURRENT_LIMIT = 5'h08;
    localparam logic [4:0] REG_DUTY_LIMIT = 5'h09;
    localparam logic [4:0] REG_DENOM_Z1 = 5'h0a;
    localparam logic [4:0] REG_DENOM_Z2 = 5'h0b;
    localparam logic [4:0] REG_DENOM_Z3 = 5'h0c;
    localparam logic [4:0] REG_NUMER0_LO = 5'h0d;
    localparam logic [4:0] REG_NUMER0_HI = 5'h0e;
    localparam logic [4:0] REG_NUMER1_LO = 5'h0f;
    localparam logic [4:0] REG_NUMER1_HI = 5'h10;
    localparam logic [4:0] REG_NUMER2_LO = 5'h11;
    localparam logic [4:0] REG_NUMER2_HI = 5'h12;
    localparam logic [4:0] REG_NUMER3_FIRST = 5'h13;
    localparam logic [4:0] REG_NUMER3_SECOND = 5'h14;
    localparam logic [4:0] REG_RUN = 5'h15;
    localparam logic [4:0] REG_FAULT = 5'h16;
    localparam logic [4:0] REG_VOLT_MON = 5'h17;
    localparam logic [4:0] REG_CURR_MON = 5'h18;
    localparam logic [4:0] REG_TEMP_MON = 5'h19;

    localparam logic [7:0] RST_DEFAULT = 8'h00;
    localparam logic [7:0] RST_SETPOINT = 8'h28;
    localparam int RUN_ON_BIT = 0;
    localparam int LOADLINE_LSB = 0;

    // frame: start, read flag, identity, address, then data
    localparam logic [3:0] HDR_BITS = 4'hb;
    localparam logic [3:0] DATA_BITS = 4'h8;
    localparam logic [4:0] WRITE_BITS = 5'h14;
    localparam logic [4:0] READ_BITS = 5'h0c;

    localparam int CLK_MHZ = 125;
    localparam int LINK_KHZ = 500;
    localparam int LINK_HALF_CYC = CLK_MHZ * 1000 / (2 * LINK_KHZ);
    localparam logic [10:0] HALF_CNT = 11'(LINK_HALF_CYC - 1);
    localparam logic [10:0] BIT_CNT = 11'(2 * LINK_HALF_CYC - 1);
    localparam logic [10:0] FIRST_CNT = 11'(3 * LINK_HALF_CYC - 1);
    localparam logic [10:0] WAIT_CNT = 11'(6 * 2 * LINK_HALF_CYC);
    localparam logic [10:0] GAP_CNT = 11'(4 * 2 * LINK_HALF_CYC);

    // setpoint decode in microvolts
    localparam logic [7:0] SP_FINE_MAX = 8'h78;
    localparam logic [7:0] SP_MID_MAX = 8'h96;
    localparam logic [7:0] SP_TOP_MAX = 8'ha8;
    localparam logic [21:0] SP_BASE_UV = 22'h07a120;
    localparam logic [21:0] SP_MID_UV = 22'h1ee5e8;
    localparam logic [21:0] SP_TOP_UV = 22'h2ab980;
    localparam logic [21:0] SP_MAX_UV = 22'h37b1d0;
    localparam logic [21:0] STEP_FINE_UV = 22'h0030d4;
    localparam logic [21:0] STEP_MID_UV = 22'h0061a8;
    localparam logic [21:0] STEP_TOP_UV = 22'h00c350;
    localparam logic [21:0] LOADLINE_UV = 22'h000064;

    // manager command port
    localparam logic [3:0] SOFT_CMD = 4'h0;
    localparam logic [3:0] SOFT_STATUS = 4'h4;
    localparam logic [3:0] SOFT_GROUP = 4'h8;
    localparam int CMD_ADDR_LSB = 8;
    localparam int CMD_ID_LSB = 13;
    localparam int CMD_READ_BIT = 18;
    localparam int CMD_MARGIN_BIT = 19;

    function automatic logic locked_reg(input logic [4:0] a);
        return a == REG_PHASE_CLOCK || a == REG_DUTY_LIMIT ||
            (a >= REG_DENOM_Z1 && a <= REG_NUMER3_SECOND);
    endfunction

    function automatic logic [21:0] setpoint_uv(input logic [7:0] c);
        if (c <= SP_FINE_MAX) begin
            return SP_BASE_UV + 22'(c) * STEP_FINE_UV;
        end else if (c <= SP_MID_MAX) begin
            return SP_MID_UV + 22'(c - SP_FINE_MAX - 8'h01) * STEP_MID_UV;
        end else if (c <= SP_TOP_MAX) begin
            return SP_TOP_UV + 22'(c - SP_MID_MAX - 8'h01) * STEP_TOP_UV;
        end
        return SP_MAX_UV;
    endfunction
endpackage
`default_nettype wire

// ---- pcb_link_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface pcb_link_if;
    logic link_clock;
    logic mgr_sd_o;
    logic mgr_sd_oe;
    logic dev_sd_o;
    logic dev_sd_oe;
    logic sync_data_line;

    // open drain with pull-up: any enabled low driver wins
    assign sync_data_line = !((mgr_sd_oe && !mgr_sd_o) ||
        (dev_sd_oe && !dev_sd_o));

    modport manager(output link_clock, output mgr_sd_o,
        output mgr_sd_oe, input sync_data_line);
    modport device(input link_clock, output dev_sd_o,
        output dev_sd_oe, input sync_data_line);
endinterface
`default_nettype wire

// ---- pcb_device.sv ----
`timescale 1ns/10ps
`default_nettype none
module pcb_device
    import pcb_pkg::*;
(
    // link to the power manager; link_clock clocks this end
    pcb_link_if.device link,
    // synchronous reset on the link clock
    input wire logic reset,
    // identity straps, raw pin levels
    input wire logic identity_strap_bit0,
    input wire logic identity_strap_bit1,
    input wire logic identity_strap_bit2,
    input wire logic identity_strap_bit3,
    input wire logic identity_strap_bit4,
    // measurements and fault events from the converter
    input wire logic [7:0] volt_meas,
    input wire logic [7:0] curr_meas,
    input wire logic [7:0] temp_meas,
    input wire logic [7:0] fault_event,
    // configuration towards the converter
    output logic output_on,
    output logic [21:0] target_uv,
    output logic [167:0] setup_image
);
    typedef enum {D_IDLE, D_HDR, D_DATA, D_RESP} pcb_dstate_e;

    pcb_dstate_e state;
    logic [7:0] regs [NUM_REGS];
    logic [4:0] strap_m;
    logic [4:0] identity;
    logic sd_m;
    logic sd_s;
    logic [7:0] volt_m;
    logic [7:0] volt_s;
    logic [7:0] curr_m;
    logic [7:0] curr_s;
    logic [7:0] temp_m;
    logic [7:0] temp_s;
    logic [7:0] fault_m;
    logic [7:0] fault_s;
    logic [3:0] cnt;
    logic [10:0] hdr;
    logic [6:0] dat;
    logic [8:0] out;
    logic [10:0] full_hdr;
    logic wr_commit;
    logic [4:0] wr_addr;
    logic [7:0] wr_data;
    logic wr_ok;
    logic [7:0] fault_clr;
    logic [21:0] sp_uv;
    logic [21:0] droop_uv;

    function automatic logic [7:0] reg_read(input logic [4:0] a);
        if (a < 5'(NUM_REGS)) begin
            return regs[a];
        end
        return 8'h00;
    endfunction

    // straps are pins: two flops before use; pull-up makes open a 1
    always_ff @(posedge link.link_clock) begin
        if (reset) begin
            strap_m <= 5'h1f;
            identity <= 5'h1f;
        end else begin
            strap_m <= {identity_strap_bit4, identity_strap_bit3,
                identity_strap_bit2, identity_strap_bit1,
                identity_strap_bit0};
            identity <= strap_m;
        end
    end

    // line and analog-side inputs come from other domains
    always_ff @(posedge link.link_clock) begin
        if (reset) begin
            sd_m <= 1'b1;
            sd_s <= 1'b1;
            volt_m <= 8'h00;
            volt_s <= 8'h00;
            curr_m <= 8'h00;
            curr_s <= 8'h00;
            temp_m <= 8'h00;
            temp_s <= 8'h00;
            fault_m <= 8'h00;
            fault_s <= 8'h00;
        end else begin
            sd_m <= link.sync_data_line;
            sd_s <= sd_m;
            volt_m <= volt_meas;
            volt_s <= volt_m;
            curr_m <= curr_meas;
            curr_s <= curr_m;
            temp_m <= temp_meas;
            temp_s <= temp_m;
            fault_m <= fault_event;
            fault_s <= fault_m;
        end
    end

    assign full_hdr = {hdr[9:0], sd_s};

    // frame receiver and read responder
    always_ff @(posedge link.link_clock) begin
        if (reset) begin
            state <= D_IDLE;
            cnt <= 4'h0;
            hdr <= 11'h000;
            dat <= 7'h00;
            out <= 9'h1ff;
            link.dev_sd_oe <= 1'b0;
        end else begin
            case (state)
                D_IDLE: begin
                    cnt <= 4'h0;
                    link.dev_sd_oe <= 1'b0;
                    if (!sd_s) begin
                        state <= D_HDR;
                    end
                end
                D_HDR: begin
                    hdr <= full_hdr;
                    cnt <= cnt + 4'h1;
                    if (cnt == HDR_BITS - 4'h1) begin
                        cnt <= 4'h0;
                        if (!full_hdr[10]) begin
                            state <= D_DATA;
                        end else if (full_hdr[9:5] == identity) begin
                            state <= D_RESP;
                            out <= {1'b0, reg_read(full_hdr[4:0])};
                        end else begin
                            state <= D_IDLE;
                        end
                    end
                end
                D_DATA: begin
                    dat <= {dat[5:0], sd_s};
                    cnt <= cnt + 4'h1;
                    if (cnt == DATA_BITS - 4'h1) begin
                        state <= D_IDLE;
                    end
                end
                D_RESP: begin
                    // start bit then data, msb first, pulled low for 0
                    link.dev_sd_oe <= !out[8];
                    out <= {out[7:0], 1'b1};
                    cnt <= cnt + 4'h1;
                    // stay two edges longer so our own last bit has left
                    // the synchroniser; a low one would look like a start
                    if (cnt == DATA_BITS + 4'h3) begin
                        link.dev_sd_oe <= 1'b0;
                        state <= D_IDLE;
                    end
                end
                default: begin
                    state <= D_IDLE;
                end
            endcase
        end
    end

    // the line is open drain: the driven level is always low
    always_ff @(posedge link.link_clock) begin
        link.dev_sd_o <= 1'b0;
    end

    assign wr_commit = state == D_DATA && cnt == DATA_BITS - 4'h1 &&
        hdr[9:5] == identity;
    assign wr_addr = hdr[4:0];
    assign wr_data = {dat, sd_s};
    // monitors and status are not plain storage; locked set needs off
    assign wr_ok = wr_commit && wr_addr <= REG_RUN &&
        !(regs[REG_RUN][RUN_ON_BIT] && locked_reg(wr_addr));
    assign fault_clr = (wr_commit && wr_addr == REG_FAULT) ?
        wr_data : 8'h00;

    // register file, eight bits per entry, addressed as mapped
    always_ff @(posedge link.link_clock) begin
        if (reset) begin
            // volatile: power loss means reset, which restores defaults
            for (int i = 0; i < NUM_REGS; i++) begin
                regs[i] <= RST_DEFAULT;
            end
            regs[REG_SETPOINT] <= RST_SETPOINT;
        end else begin
            if (wr_ok) begin
                // setup range 00h-14h and run at 15h; 04h, 09h and 0Ah-14h only while run is off
                regs[wr_addr] <= wr_data;
            end
            // a fault arriving with its clear stays set
            regs[REG_FAULT] <= (regs[REG_FAULT] & ~fault_clr) | fault_s;
            regs[REG_VOLT_MON] <= volt_s;
            regs[REG_CURR_MON] <= curr_s;
            regs[REG_TEMP_MON] <= temp_s;
        end
    end

    assign sp_uv = setpoint_uv(regs[REG_SETPOINT]);
    assign droop_uv = 22'(regs[REG_CURRENT_LIMIT][LOADLINE_LSB +: 4]) *
        22'(curr_s) * LOADLINE_UV;

    // droop lowers the target as current rises; floor at zero
    always_ff @(posedge link.link_clock) begin
        if (reset) begin
            output_on <= 1'b0;
            target_uv <= 22'h000000;
        end else begin
            output_on <= regs[REG_RUN][RUN_ON_BIT];
            target_uv <= (droop_uv > sp_uv) ? 22'h000000 :
                sp_uv - droop_uv;
        end
    end

    for (genvar g = 0; g < 21; g++) begin : g_setup
        assign setup_image[8 * g +: 8] = regs[g];
    end
endmodule
`default_nettype wire

// ---- pcb_manager.sv ----
`timescale 1ns/10ps
`default_nettype none
module pcb_manager
    import pcb_pkg::*;
(
    // system clock and reset
    input wire logic clock,
    input wire logic reset,
    // software port
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    // link to the modules
    pcb_link_if.manager link
);
    typedef enum {M_IDLE, M_SEND, M_WAIT, M_RECV, M_GAP} pcb_mstate_e;

    pcb_mstate_e state;
    logic [10:0] ph;
    logic tick;
    logic sd_m;
    logic sd_s;
    logic [19:0] sh;
    logic [4:0] nbits;
    logic [4:0] cnt;
    logic [10:0] tmr;
    logic [7:0] rx;
    logic [7:0] rd_byte;
    logic busy;
    logic refused;
    logic no_answer;
    logic grouped;
    logic setup_done;
    logic run_on;
    logic cmd_go;
    logic cmd_bad;
    logic [4:0] c_reg;
    logic c_read;

    // the line clock is ours: a divided copy of the system clock
    always_ff @(posedge clock) begin
        if (reset) begin
            ph <= 11'h000;
            link.link_clock <= 1'b0;
        end else begin
            ph <= (ph == HALF_CNT) ? 11'h000 : ph + 11'h001;
            if (ph == HALF_CNT) begin
                link.link_clock <= !link.link_clock;
            end
        end
    end
    // bits change on the falling line edge, sampled on the rising one
    assign tick = ph == HALF_CNT && link.link_clock;

    always_ff @(posedge clock) begin
        if (reset) begin
            sd_m <= 1'b1;
            sd_s <= 1'b1;
        end else begin
            sd_m <= link.sync_data_line;
            sd_s <= sd_m;
        end
    end

    assign c_reg = wdata[CMD_ADDR_LSB +: 5];
    assign c_read = wdata[CMD_READ_BIT];
    assign cmd_go = wr && addr == SOFT_CMD && state == M_IDLE;
    assign cmd_bad = !c_read && (
        (wdata[CMD_MARGIN_BIT] && !grouped) ||
        (run_on && locked_reg(c_reg)) ||
        (c_reg == REG_RUN && wdata[RUN_ON_BIT] && !setup_done));

    always_ff @(posedge clock) begin
        if (reset) begin
            state <= M_IDLE;
            sh <= 20'h00000;
            nbits <= 5'h00;
            cnt <= 5'h00;
            tmr <= 11'h000;
            rx <= 8'h00;
            rd_byte <= 8'h00;
            refused <= 1'b0;
            no_answer <= 1'b0;
            setup_done <= 1'b0;
            run_on <= 1'b0;
            link.mgr_sd_oe <= 1'b0;
        end else begin
            case (state)
                M_IDLE: begin
                    cnt <= 5'h00;
                    if (cmd_go) begin
                        refused <= cmd_bad;
                        no_answer <= 1'b0;
                        if (!cmd_bad) begin
                            state <= M_SEND;
                            sh <= {1'b0, wdata[CMD_READ_BIT:0]};
                            nbits <= c_read ? READ_BITS : WRITE_BITS;
                            if (!c_read && c_reg == REG_NUMER3_SECOND) begin
                                setup_done <= 1'b1;
                            end
                            if (!c_read && c_reg == REG_RUN) begin
                                run_on <= wdata[RUN_ON_BIT];
                            end
                        end
                    end
                end
                M_SEND: begin
                    if (tick) begin
                        if (cnt == nbits) begin
                            link.mgr_sd_oe <= 1'b0;
                            tmr <= 11'h000;
                            // the shifter has rotated, so decide by length
                            state <= (nbits == READ_BITS) ? M_WAIT : M_GAP;
                        end else begin
                            link.mgr_sd_oe <= !sh[19];
                            sh <= {sh[18:0], sh[19]};
                            cnt <= cnt + 5'h01;
                        end
                    end
                end
                M_WAIT: begin
                    tmr <= tmr + 11'h001;
                    cnt <= 5'h00;
                    // our own last header bit is still in the synchroniser
                    if (!sd_s && tmr > 11'h003) begin
                        tmr <= FIRST_CNT;
                        state <= M_RECV;
                    end else if (tmr == WAIT_CNT) begin
                        // no module owns that identity
                        no_answer <= 1'b1;
                        tmr <= 11'h000;
                        state <= M_GAP;
                    end
                end
                M_RECV: begin
                    tmr <= tmr - 11'h001;
                    if (tmr == 11'h000) begin
                        rx <= {rx[6:0], sd_s};
                        tmr <= BIT_CNT;
                        cnt <= cnt + 5'h01;
                        if (cnt == 5'(DATA_BITS) - 5'h01) begin
                            rd_byte <= {rx[6:0], sd_s};
                            state <= M_GAP;
                        end
                    end
                end
                M_GAP: begin
                    // let the module return to idle before a new start
                    tmr <= tmr + 11'h001;
                    if (tmr == GAP_CNT) begin
                        state <= M_IDLE;
                    end
                end
                default: begin
                    state <= M_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            grouped <= 1'b0;
        end else if (wr && addr == SOFT_GROUP) begin
            grouped <= wdata[0];
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            busy <= 1'b0;
            link.mgr_sd_o <= 1'b0;
        end else begin
            busy <= state != M_IDLE || (cmd_go && !cmd_bad);
            link.mgr_sd_o <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (reset || !rd) begin
            rdata <= 32'h00000000;
        end else if (addr == SOFT_STATUS) begin
            rdata <= {16'h0000, rd_byte, 5'h00, refused, no_answer, busy};
        end else if (addr == SOFT_GROUP) begin
            rdata <= {31'h00000000, grouped};
        end else begin
            rdata <= 32'h00000000;
        end
    end
endmodule
`default_nettype wire

// ---- pcb_device_note_unused.sv ----
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// ---- pcb_link_asserts.sv ----
`timescale 1ns/10ps
`default_nettype none
module pcb_link_asserts
    import pcb_pkg::*;
(
    // system side
    input wire logic clock,
    input wire logic reset,
    // link wires
    input wire logic link_clock,
    input wire logic mgr_sd_o,
    input wire logic mgr_sd_oe,
    input wire logic dev_sd_o,
    input wire logic dev_sd_oe,
    input wire logic sync_data_line
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);

    logic prev_lc;
    logic seen_lc;
    logic [10:0] half_cnt;

    // the first toggle after reset has no full half period behind it
    always_ff @(posedge clock) begin
        prev_lc <= link_clock;
        seen_lc <= reset ? 1'b0 : (seen_lc || link_clock != prev_lc);
        half_cnt <= (link_clock != prev_lc) ? 11'h000 : half_cnt + 11'h001;
    end

    link_half_period_a:
        assert property (seen_lc && link_clock != prev_lc |->
            half_cnt == HALF_CNT) else $error("link half period wrong");
    reset_quiet_a:
        assert property ($fell(reset) |-> !link_clock && !mgr_sd_oe)
            else $error("link busy after reset");
    mgr_pulls_low_a:
        assert property (mgr_sd_oe |-> !mgr_sd_o && !sync_data_line)
            else $error("manager drive not low");
    dev_pulls_low_a:
        assert property (dev_sd_oe |-> !dev_sd_o && !sync_data_line)
            else $error("device drive not low");
    mgr_falling_edge_a:
        assert property ($changed(mgr_sd_oe) |-> !link_clock)
            else $error("manager bit not on falling edge");
    mgr_bit_holds_a:
        assert property ($changed(mgr_sd_oe) |=> $stable(mgr_sd_oe)[*8])
            else $error("manager bit too short");
    dev_bit_holds_a:
        assert property ($changed(dev_sd_oe) |=> $stable(dev_sd_oe)[*8])
            else $error("device bit too short");
    no_contention_a:
        assert property (!(mgr_sd_oe && dev_sd_oe))
            else $error("both ends drive the line");
    reply_after_header_a:
        assert property ($rose(dev_sd_oe) |-> $past(mgr_sd_oe, 250) == 1'b0)
            else $error("device answered during header");

    cover property ($rose(mgr_sd_oe));
    cover property ($rose(dev_sd_oe));
    cover property (seen_lc && link_clock != prev_lc);
endmodule
`default_nettype wire

// ---- pol_config_register_bank_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module pol_config_register_bank_tb_top;
    import pcb_pkg::*;
    typedef struct {
        logic [31:0] val;
        logic [31:0] mask;
        string nm;
    } pcb_note_s;

    logic clock = 1'b0;
    logic reset = 1'b1;
    logic dev_reset = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic tag_rd = 1'b0;
    logic [31:0] rdata;
    logic [4:0] strap;
    logic [7:0] volt_meas;
    logic [7:0] curr_meas;
    logic [7:0] temp_meas;
    logic output_on;
    logic [21:0] target_uv;
    logic [167:0] setup_image;
    logic rd_d = 1'b0;
    logic peek = 1'b0;
    logic [31:0] peek_val = 32'h0;
    logic [31:0] seen;
    int n_fail = 0;
    int n_tests = 0;
    int seed = 79;
    pcb_note_s notes[$];
    pcb_note_s cur;
    logic [4:0] id;
    logic [7:0] sp;
    logic [21:0] exp_uv;

    always #4 clock = ~clock;

    pcb_link_if i_pcb_link_if();
    pcb_manager i_pcb_manager(.clock(clock), .reset(reset), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .link(i_pcb_link_if));
    pcb_device i_pcb_device(.link(i_pcb_link_if), .reset(dev_reset),
        .identity_strap_bit0(strap[0]), .identity_strap_bit1(strap[1]),
        .identity_strap_bit2(strap[2]), .identity_strap_bit3(strap[3]),
        .identity_strap_bit4(strap[4]), .volt_meas(volt_meas),
        .curr_meas(curr_meas), .temp_meas(temp_meas),
        .fault_event(8'h00), .output_on(output_on),
        .target_uv(target_uv), .setup_image(setup_image));
    pcb_link_asserts i_pcb_link_asserts(.clock(clock), .reset(reset),
        .link_clock(i_pcb_link_if.link_clock),
        .mgr_sd_o(i_pcb_link_if.mgr_sd_o),
        .mgr_sd_oe(i_pcb_link_if.mgr_sd_oe),
        .dev_sd_o(i_pcb_link_if.dev_sd_o),
        .dev_sd_oe(i_pcb_link_if.dev_sd_oe),
        .sync_data_line(i_pcb_link_if.sync_data_line));

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
        @(posedge clock);
    endtask

    task automatic strobe_rd(input logic [3:0] a, input logic keep);
        addr <= a;
        rd <= 1'b1;
        tag_rd <= keep;
        @(posedge clock);
        rd <= 1'b0;
        @(posedge clock);
    endtask

    task automatic rd_reg(input logic [3:0] a, input logic [31:0] v,
            input logic [31:0] m, input string s);
        notes.push_back('{v, m, s});
        strobe_rd(a, 1'b1);
    endtask

    task automatic chk(input logic [31:0] x, input logic [31:0] v,
            input logic [31:0] m, input string s);
        notes.push_back('{v, m, s});
        peek_val <= x;
        peek <= 1'b1;
        @(posedge clock);
        peek <= 1'b0;
        @(posedge clock);
    endtask

    // busy is polled sparsely: a frame lasts thousands of cycles
    task automatic wait_idle();
        int k;
        k = 0;
        do begin
            repeat (40) @(posedge clock);
            strobe_rd(4'h4, 1'b0);
            k++;
        end while (rdata[0] !== 1'b0 && k < 400);
        if (k >= 400) begin
            n_fail++;
            $display("wrong value busy expected 0 seen 1");
        end
    endtask

    task automatic cmd(input logic rdf, input logic [4:0] dst,
            input logic [4:0] r, input logic [7:0] d);
        wr_reg(4'h0, {12'h000, 1'b0, rdf, dst, r, d});
        wait_idle();
    endtask

    always @(posedge clock) begin
        if (rd_d || peek) begin
            cur = notes.pop_front();
            seen = (rd_d ? rdata : peek_val) & cur.mask;
            n_tests++;
            if (seen !== cur.val) begin
                n_fail++;
                $display("wrong value %s expected %h seen %h", cur.nm,
                    cur.val, seen);
            end
        end
        rd_d <= rd && tag_rd;
    end

    initial begin
        repeat (100000) @(posedge clock);
        n_fail++;
        $display("watchdog expired");
        wrap_up();
    end

    initial begin
        strap = 5'($random(seed));
        volt_meas = 8'($random(seed));
        curr_meas = 8'($random(seed));
        temp_meas = 8'($random(seed));
        sp = 8'($random(seed)) % 8'h79;
        // a strap left open reads 1, tied low reads 0
        id = strap;
        repeat (10) @(posedge clock);
        reset <= 1'b0;
        repeat (4) @(posedge i_pcb_link_if.link_clock);
        @(posedge clock);
        dev_reset <= 1'b0;
        repeat (4) @(posedge i_pcb_link_if.link_clock);
        @(posedge clock);
        chk(setup_image[31:0], 32'h0, '1, "regs 00-03");
        chk(setup_image[63:32], {RST_SETPOINT, 24'h0}, '1, "regs 04-07");
        chk(32'(|setup_image[167:64]), 32'h0, '1, "regs 08-14");
        exp_uv = SP_BASE_UV + 22'(RST_SETPOINT) * STEP_FINE_UV;
        chk(32'({output_on, target_uv}), 32'(exp_uv), '1, "outputs");
        rd_reg(4'hc, 32'h0, '1, "unmapped port");
        rd_reg(4'h4, 32'h0, '1, "status at reset");
        $display("test reset done");
        cmd(1'b0, id, REG_SETPOINT, sp);
        chk(32'(setup_image[63:56]), 32'(sp), '1, "setpoint");
        cmd(1'b0, id ^ 5'h01, REG_ON_DELAY, 8'ha5);
        chk(32'(setup_image[47:40]), 32'h0, '1, "foreign write");
        cmd(1'b1, id ^ 5'h10, REG_VOLT_MON, 8'h00);
        rd_reg(4'h4, 32'h2, 32'h6, "no answer");
        $display("test identity done");
        cmd(1'b0, id, REG_RUN, 8'h01);
        rd_reg(4'h4, 32'h4, 32'h4, "early run");
        chk(32'(output_on), 32'h0, '1, "early run on");
        cmd(1'b0, id, REG_PHASE_CLOCK, 8'h5a);
        cmd(1'b0, id, REG_NUMER3_SECOND, 8'hc3);
        chk(32'(setup_image[39:32]), 32'h5a, '1, "phase clock");
        chk(32'(setup_image[167:160]), 32'hc3, '1, "coef 14");
        $display("test setup done");
        cmd(1'b0, id, REG_RUN, 8'h01);
        chk(32'(output_on), 32'h1, '1, "run on");
        exp_uv = SP_BASE_UV + 22'(sp) * STEP_FINE_UV;
        chk(32'(target_uv), 32'(exp_uv), '1, "target");
        cmd(1'b0, id, REG_CURRENT_LIMIT, 8'h03);
        exp_uv = exp_uv - 22'(curr_meas) * 22'h3 * LOADLINE_UV;
        chk(32'(target_uv), 32'(exp_uv), '1, "load line");
        cmd(1'b0, id, REG_DUTY_LIMIT, 8'h77);
        rd_reg(4'h4, 32'h4, 32'h4, "locked write");
        chk(32'(setup_image[79:72]), 32'h0, '1, "duty locked");
        cmd(1'b1, id, REG_VOLT_MON, 8'h00);
        rd_reg(4'h4, {16'h0, volt_meas, 8'h0}, 32'hff06, "monitor");
        $display("test running done");
        cmd(1'b0, id, REG_RUN, 8'h00);
        cmd(1'b0, id, REG_DUTY_LIMIT, 8'h77);
        chk(32'(setup_image[79:72]), 32'h77, '1, "duty free");
        wr_reg(4'h0, 32'h00080000);
        wait_idle();
        rd_reg(4'h4, 32'h4, 32'h4, "margin no group");
        wr_reg(4'h8, 32'h1);
        rd_reg(4'h8, 32'h1, '1, "group set");
        $display("test stopped done");
        repeat (4) @(posedge clock);
        wrap_up();
    end
endmodule
`default_nettype wire
